// file: include/ppr_pkg.sv
// Package for the peripheral pin remap block: register map, field layout, codes.
package ppr_pkg;
	localparam int unsigned NUM_PINS    = 16;
	localparam int unsigned NUM_IN_FN   = 14;
	localparam int unsigned SEL_W       = 5;
	localparam int unsigned ADDR_W      = 12;
	localparam int unsigned NUM_IN_REGS = 7;
	localparam int unsigned NUM_OUT_REGS = 8;
	localparam int unsigned NUM_REGS    = NUM_IN_REGS + NUM_OUT_REGS;
	localparam int unsigned REG_IDX_W   = 4;

	// Byte offsets: input selectors first, then one output register per pin pair
	localparam logic [ADDR_W-1:0] IN_BASE_ADDR  = 12'h000;
	localparam logic [ADDR_W-1:0] OUT_BASE_ADDR = 12'h040;
	localparam logic [ADDR_W-1:0] UART_INPUT_PIN_SELECT_ADDR  = 12'h014;
	localparam logic [ADDR_W-1:0] SPI_INPUT_PIN_SELECT_ADDR   = 12'h018;
	localparam logic [ADDR_W-1:0] PIN6_PIN7_OUTPUT_SELECT_ADDR = 12'h04c;
	localparam logic [ADDR_W-1:0] PIN8_PIN9_OUTPUT_SELECT_ADDR = 12'h050;

	// Field positions inside each 16-bit selector register
	localparam int unsigned HI_FIELD_LSB = 8;
	localparam int unsigned LO_FIELD_LSB = 0;

	localparam logic [SEL_W-1:0] IN_SEL_RESET  = 5'h1f;
	localparam logic [SEL_W-1:0] IN_SEL_GROUND = 5'h1f;
	localparam logic [SEL_W-1:0] OUT_SEL_RESET = 5'h00;
	localparam logic [SEL_W-1:0] OUT_SEL_NULL  = 5'h00;

	// Input function indices, two per input register (low field first)
	localparam int unsigned FN_EXT_EXTERNAL_INTERRUPT_ONE   = 0;
	localparam int unsigned FN_EXT_EXTERNAL_INTERRUPT_TWO   = 1;
	localparam int unsigned FN_T2_CLK     = 2;
	localparam int unsigned FN_T3_CLK     = 3;
	localparam int unsigned FN_CAPTURE1   = 4;
	localparam int unsigned FN_CAPTURE2   = 5;
	localparam int unsigned FN_CAPTURE7   = 6;
	localparam int unsigned FN_CAPTURE8   = 7;
	localparam int unsigned FN_CMP_FAULT  = 8;
	localparam int unsigned FN_UART_RX    = 9;
	localparam int unsigned FN_UART_CTS   = 10;
	localparam int unsigned FN_SPI_DATA   = 11;
	localparam int unsigned FN_SPI_CLK    = 12;
	localparam int unsigned FN_SPI_SS     = 13;

	// Output function codes: code 0 is null, codes 1..NUM_OUT_FN are peripheral outputs
	localparam int unsigned NUM_OUT_FN = 31;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} ppr_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ppr_apb_rsp_t;
endpackage

// file: core/ppr_sel_store.sv
// Selector storage: one pair of 5-bit fields per register, registered read port.
`timescale 1ns/1ps
`default_nettype none
module ppr_sel_store #(
	parameter int unsigned N_REGS  = 15,
	parameter int unsigned N_IN    = 7,
	parameter int unsigned IDX_W   = 4
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	input  wire logic                        wr_en,
	input  wire logic [IDX_W-1:0]            wr_idx,
	input  wire logic [2*ppr_pkg::SEL_W-1:0] wr_data,
	input  wire logic [IDX_W-1:0]            rd_idx,
	output logic      [2*ppr_pkg::SEL_W-1:0] rd_data,
	output logic      [N_REGS*2*ppr_pkg::SEL_W-1:0] all_q
);
	localparam int unsigned PW = 2 * ppr_pkg::SEL_W;

	initial begin
		if (N_REGS > (1 << IDX_W) || N_IN > N_REGS)
			$error("ppr_sel_store: bad sizing");
	end

	typedef struct packed {
		logic [N_REGS-1:0][PW-1:0] mem;
		logic [PW-1:0]             rd;
	} ppr_store_state_t;

	ppr_store_state_t s_q;
	ppr_store_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (clk_en) begin
			if (wr_en && 32'(wr_idx) < N_REGS)
				s_d.mem[wr_idx] = wr_data;
			s_d.rd = (32'(rd_idx) < N_REGS) ? s_q.mem[rd_idx] : '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < N_REGS; i++) begin
				// Input selectors reset to ground-tied, output selectors to null
				s_q.mem[i] <= (i < N_IN) ? {ppr_pkg::IN_SEL_RESET, ppr_pkg::IN_SEL_RESET}
				                         : {ppr_pkg::OUT_SEL_RESET, ppr_pkg::OUT_SEL_RESET};
			end
			s_q.rd <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rd;
	assign all_q   = s_q.mem;
endmodule
`default_nettype wire

// file: core/ppr_remap.sv
// Peripheral pin remap: per-function input selection and per-pin output selection.
`timescale 1ns/1ps
`default_nettype none
module ppr_remap #(
	parameter int unsigned N_PINS   = ppr_pkg::NUM_PINS,
	parameter int unsigned N_OUT_FN = ppr_pkg::NUM_OUT_FN
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire ppr_pkg::ppr_apb_req_t apb_req,
	output ppr_pkg::ppr_apb_rsp_t      apb_rsp,
	input  wire logic [N_PINS-1:0]     pin_in,
	input  wire logic [N_OUT_FN:1]     periph_out,
	input  wire logic [N_OUT_FN:1]     periph_out_en,
	output logic [N_PINS-1:0]          pin_out,
	output logic [N_PINS-1:0]          pin_oe,
	output logic [ppr_pkg::NUM_IN_FN-1:0] periph_in
);
	localparam int unsigned SW  = ppr_pkg::SEL_W;
	localparam int unsigned NR  = ppr_pkg::NUM_REGS;
	localparam int unsigned NI  = ppr_pkg::NUM_IN_REGS;
	localparam int unsigned IW  = ppr_pkg::REG_IDX_W;

	initial begin
		if (N_PINS != 2 * ppr_pkg::NUM_OUT_REGS || N_PINS > (1 << (SW - 1)))
			$error("ppr_remap: pin count must match the output register pairs");
		if (N_OUT_FN >= (1 << SW) || N_OUT_FN < 1)
			$error("ppr_remap: output function count exceeds selector code space");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_DONE = 2'b10
	} ppr_bus_st_t;

	typedef struct packed {
		ppr_bus_st_t                    st;
		ppr_pkg::ppr_apb_rsp_t          rsp;
		logic [N_PINS-1:0]              pout;
		logic [N_PINS-1:0]              poe;
		logic [ppr_pkg::NUM_IN_FN-1:0]  pin_fn;
	} ppr_state_t;

	ppr_state_t s_q;
	ppr_state_t s_d;

	// Address decode: word index within the selector space
	logic                    hit;
	logic [IW-1:0]           idx;
	logic [ppr_pkg::ADDR_W-1:0] a;
	always_comb begin
		a   = apb_req.paddr;
		hit = 1'b0;
		idx = '0;
		if (a[1:0] == 2'b00) begin
			if (a >= ppr_pkg::IN_BASE_ADDR && a < ppr_pkg::IN_BASE_ADDR + 12'(4 * NI)) begin
				hit = 1'b1;
				idx = IW'((a - ppr_pkg::IN_BASE_ADDR) >> 2);
			end else if (a >= ppr_pkg::OUT_BASE_ADDR
			             && a < ppr_pkg::OUT_BASE_ADDR + 12'(4 * ppr_pkg::NUM_OUT_REGS)) begin
				hit = 1'b1;
				idx = IW'(((a - ppr_pkg::OUT_BASE_ADDR) >> 2) + 12'(NI));
			end
		end
	end

	logic                      wr_en;
	logic [2*SW-1:0]           wr_data;
	logic [2*SW-1:0]           rd_data;
	logic [NR*2*SW-1:0]        all_flat;
	logic [NR-1:0][2*SW-1:0]   regs;

	// Only the two implemented 5-bit fields are stored; other bits are dropped
	assign wr_data = {apb_req.pwdata[ppr_pkg::HI_FIELD_LSB +: SW],
	                  apb_req.pwdata[ppr_pkg::LO_FIELD_LSB +: SW]};
	assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite && hit
	                 && s_q.st == ST_IDLE;
	assign regs    = all_flat;

	ppr_sel_store #(
		.N_REGS (NR),
		.N_IN   (NI),
		.IDX_W  (IW)
	) u_store (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.wr_en   (wr_en),
		.wr_idx  (idx),
		.wr_data (wr_data),
		.rd_idx  (idx),
		.rd_data (rd_data),
		.all_q   (all_flat)
	);

	// Per-function input selection: each function owns one field
	logic [ppr_pkg::NUM_IN_FN-1:0] fn_next;
	genvar gf;
	generate
		for (gf = 0; gf < ppr_pkg::NUM_IN_FN; gf++) begin : g_in_fn
			logic [SW-1:0] sel;
			assign sel = regs[gf / 2][(gf % 2) * SW +: SW];
			// Codes past the last pin, including all-ones, read as ground
			assign fn_next[gf] = (32'(sel) < N_PINS) ? pin_in[sel[SW-2:0]] : 1'b0;
		end
	endgenerate

	// Per-pin output selection
	logic [N_PINS-1:0] pout_next;
	logic [N_PINS-1:0] poe_next;
	genvar gp;
	generate
		for (gp = 0; gp < N_PINS; gp++) begin : g_pin
			logic [SW-1:0] code;
			// Odd pin in upper field, even pin in lower field
			assign code = regs[NI + gp / 2][(gp % 2) * SW +: SW];
			always_comb begin
				pout_next[gp] = 1'b0;
				poe_next[gp]  = 1'b0;
				if (code != ppr_pkg::OUT_SEL_NULL && 32'(code) <= N_OUT_FN) begin
					pout_next[gp] = periph_out[code];
					poe_next[gp]  = periph_out_en[code];
				end
			end
		end
	endgenerate

	// APB slave: writes complete after one wait state, reads wait one cycle more for the store's register
	always_comb begin
		s_d = s_q;
		s_d.rsp.pready  = 1'b0;
		s_d.rsp.pslverr = 1'b0;
		s_d.pout   = pout_next;
		s_d.poe    = poe_next;
		s_d.pin_fn = fn_next;
		unique case (s_q.st)
			ST_IDLE: begin
				if (apb_req.psel && apb_req.penable) begin
					if (apb_req.pwrite || !hit) begin
						s_d.rsp.pready  = 1'b1;
						s_d.rsp.pslverr = !hit;
						s_d.rsp.prdata  = '0;
						s_d.st          = ST_DONE;
					end else begin
						s_d.st = ST_READ;
					end
				end
			end
			ST_READ: begin
				s_d.rsp.pready = 1'b1;
				// Unimplemented bits read as zero
				s_d.rsp.prdata = '0;
				s_d.rsp.prdata[ppr_pkg::HI_FIELD_LSB +: SW] = rd_data[SW +: SW];
				s_d.rsp.prdata[ppr_pkg::LO_FIELD_LSB +: SW] = rd_data[0 +: SW];
				s_d.st = ST_DONE;
			end
			ST_DONE: begin
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign apb_rsp   = s_q.rsp;
	assign pin_out   = s_q.pout;
	assign pin_oe    = s_q.poe;
	assign periph_in = s_q.pin_fn;

	a_null_pin_off: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && regs[NI + 6 / 2][0 +: SW] == ppr_pkg::OUT_SEL_NULL
		|=> !pin_oe[6] && !pin_out[6])
		else $error("null code pin 6 is driven");
	a_out_follows_code: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && regs[NI + 3][SW +: SW] == 5'h01 |=> pin_out[7] == $past(periph_out[1]))
		else $error("pin 7 does not follow output code 1");
	a_in_ground_tie: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && regs[4][0 +: SW] == ppr_pkg::IN_SEL_GROUND |=> !periph_in[ppr_pkg::FN_UART_RX - 1])
		else $error("ground-tied input not low");
	a_in_pin_route: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && regs[4][SW +: SW] == 5'h03 |=> periph_in[ppr_pkg::FN_UART_RX] == $past(pin_in[3]))
		else $error("uart receive not routed from pin 3");
	a_read_zero_bits: assert property (@(posedge ref_clk) disable iff (rst)
		apb_rsp.pready |-> apb_rsp.prdata[15:13] == 3'h0 && apb_rsp.prdata[7:5] == 3'h0)
		else $error("unimplemented bits read nonzero");
	sequence s_rd_access;
		apb_req.psel && apb_req.penable && !apb_req.pwrite && hit && s_q.st == ST_IDLE && clk_en;
	endsequence
	a_read_latency: assert property (@(posedge ref_clk) disable iff (rst)
		s_rd_access ##1 clk_en |=> apb_rsp.pready)
		else $error("read not answered in two cycles");
	a_write_ack: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && clk_en |=> apb_rsp.pready && !apb_rsp.pslverr)
		else $error("write not acknowledged next cycle");
	a_pin_oe_src: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && regs[NI][0 +: SW] == 5'h02 |=> pin_oe[0] == $past(periph_out_en[2]))
		else $error("pin 0 enable does not follow code 2");
	a_fn_indep: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && regs[0][0 +: SW] == 5'h00 && regs[0][SW +: SW] == 5'h01
		|=> periph_in[0] == $past(pin_in[0]) && periph_in[1] == $past(pin_in[1]))
		else $error("interrupt inputs not routed independently");
endmodule
`default_nettype wire

// file: testbench/peripheral_pin_remap_test.sv
// Self-checking bench for the peripheral pin remap block.
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_remap_test;
	logic                  ref_clk;
	logic                  rst;
	ppr_pkg::ppr_apb_req_t req;
	ppr_pkg::ppr_apb_rsp_t rsp;
	logic [15:0]           pin_in;
	logic [31:1]           po;
	logic [31:1]           poe;
	logic [15:0]           pin_out;
	logic [15:0]           pin_oe;
	logic [13:0]           periph_in;
	int                    error_cnt = 0;
	int                    n_checks = 0;
	int                    cycles = 0;
	logic [31:0]           rd;
	logic                  err;
	logic [4:0]            a;
	logic [4:0]            b;
	logic [11:0]           ad;

	ppr_remap dut_u (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.clk_en        (1'b1),
		.apb_req       (req),
		.apb_rsp       (rsp),
		.pin_in        (pin_in),
		.periph_out    (po),
		.periph_out_en (poe),
		.pin_out       (pin_out),
		.pin_oe        (pin_oe),
		.periph_in     (periph_in)
	);

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The whole run needs well under two thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; leaves one idle edge so no signal is driven twice
	task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= adr;
		req.pwdata  <= wd;
		@(posedge ref_clk);
		req.penable <= 1'b1;
		do @(posedge ref_clk); while (rsp.pready !== 1'b1);
		rd  = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rreg(input logic [11:0] adr, input logic [31:0] exp, input logic eerr);
		apb(1'b0, adr, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, eerr});
	endtask

	// Routing is registered: three edges leave margin over the one-cycle latency
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	initial begin
		rst = 1'b1;
		req = '0;
		pin_in = 16'h0;
		po = '0;
		poe = '0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int k = 0; k < 7; k++) begin
			rreg(ppr_pkg::IN_BASE_ADDR + 12'(4 * k), 32'h1f1f, 1'b0);
		end
		for (int j = 0; j < 8; j++) begin
			rreg(ppr_pkg::OUT_BASE_ADDR + 12'(4 * j), 32'h0, 1'b0);
		end
		pin_in <= 16'hffff;
		settle();
		chk({18'h0, periph_in}, 32'h0);
		$display("test reset values done");

		// Each function gets its own pin, unused bits written as ones
		for (int k = 0; k < 7; k++) begin
			// Source pins stay inside 0..15 and never coincide within one register
			a = 5'(k);
			b = 5'(15 - k);
			ad = ppr_pkg::IN_BASE_ADDR + 12'(4 * k);
			apb(1'b1, ad, {19'h7ffff, b, 3'h7, a});
			rreg(ad, {19'h0, b, 3'h0, a}, 1'b0);
			pin_in <= 16'h1 << a;
			settle();
			chk({30'h0, periph_in[2*k+1], periph_in[2*k]}, 32'h1);
			pin_in <= 16'h1 << b;
			settle();
			chk({30'h0, periph_in[2*k+1], periph_in[2*k]}, 32'h2);
		end
		$display("test input routing done");

		apb(1'b1, ppr_pkg::OUT_BASE_ADDR, 32'hffffffe2);
		rreg(ppr_pkg::OUT_BASE_ADDR, 32'h1f02, 1'b0);
		apb(1'b1, ppr_pkg::PIN6_PIN7_OUTPUT_SELECT_ADDR, 32'h0111);
		apb(1'b1, ppr_pkg::PIN8_PIN9_OUTPUT_SELECT_ADDR, 32'h0200);
		for (int p = 0; p < 2; p++) begin
			po <= (p == 0) ? 31'h15555555 : 31'h6aaaaaaa;
			poe <= (p == 0) ? 31'h6aaaaaaa : 31'h15555555;
			settle();
			chk({24'h0, pin_oe[9:6], pin_out[9:6]},
				{24'h0, poe[2], 1'b0, poe[1], poe[17], po[2], 1'b0, po[1], po[17]});
			chk({28'h0, pin_oe[1:0], pin_out[1:0]},
				{28'h0, poe[31], poe[2], po[31], po[2]});
		end
		$display("test output routing done");

		rreg(12'h100, 32'h0, 1'b1);
		rreg(12'h042, 32'h0, 1'b1);
		apb(1'b1, 12'h100, 32'h1f);
		chk({31'h0, err}, 32'h1);
		$display("test unmapped access done");
		give_verdict();
	end
endmodule
`default_nettype wire
